// File: sad_pkg.sv
/*
 * constants, types and address map of the system address decoder
 * assumes a 32-bit byte address from every bus master
 */
package sad_pkg;

    // ----------------------------------------------------------------
    // bus masters, swap modes, targets
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SAD_M_INSTR = 2'h0,
        SAD_M_DATA  = 2'h1,
        SAD_M_DMA   = 2'h2,
        SAD_M_HOST  = 2'h3
    } sad_master_t;

    typedef enum logic [1:0] {
        SAD_SWAP_ROM     = 2'h0,
        SAD_SWAP_SDRAM   = 2'h1,
        SAD_SWAP_ASYNC   = 2'h2,
        SAD_SWAP_TIMEOUT = 2'h3
    } sad_swap_t;

    typedef enum logic [4:0] {
        SAD_T_NONE     = 5'h00,
        SAD_T_BOOT_ROM = 5'h01,
        SAD_T_SDRAM    = 5'h02,
        SAD_T_ASYNC    = 5'h03,
        SAD_T_ITCM     = 5'h04,
        SAD_T_DTCM     = 5'h05,
        SAD_T_ICU      = 5'h06,
        SAD_T_NET      = 5'h07,
        SAD_T_PBUF     = 5'h08,
        SAD_T_DMA_REG  = 5'h09,
        SAD_T_DMA_SRAM = 5'h0A,
        SAD_T_EMC_REG  = 5'h0B,
        SAD_T_PREG     = 5'h0C,
        SAD_T_SPI1     = 5'h0D,
        SAD_T_SPI2     = 5'h0E,
        SAD_T_WDOG     = 5'h0F,
        SAD_T_IFILT    = 5'h10,
        SAD_T_FCNT     = 5'h11
    } sad_target_t;

    // ----------------------------------------------------------------
    // window bounds
    // ----------------------------------------------------------------
    localparam logic [31:0] SAD_LOW_BASE   = 32'h0000_0000;
    localparam logic [31:0] SAD_LOW_LAST   = 32'h03FF_FFFF;
    localparam logic [31:0] SAD_ITCM_LAST  = 32'h0003_FFFF;
    localparam logic [31:0] SAD_DTCM_BASE  = 32'h0800_0000;
    localparam logic [31:0] SAD_DTCM_LAST  = 32'h0803_FFFF;
    localparam logic [31:0] SAD_ICU_BASE   = 32'h1000_0000;
    localparam logic [31:0] SAD_ICU_LAST   = 32'h105F_FFFF;
    localparam logic [31:0] SAD_NET_BASE   = 32'h1060_0000;
    localparam logic [31:0] SAD_NET_LAST   = 32'h107F_FFFF;
    localparam logic [31:0] SAD_PBUF_BASE  = 32'h1080_0000;
    localparam logic [31:0] SAD_PBUF_LAST  = 32'h109F_FFFF;
    localparam logic [31:0] SAD_DMA_BASE   = 32'h10A0_0000;
    localparam logic [31:0] SAD_DMA_LAST   = 32'h10AF_FFFF;
    localparam logic [31:0] SAD_DMAR_LAST  = 32'h10A0_00AF;
    localparam logic [31:0] SAD_DMAS_LAST  = 32'h10A0_12AF;
    localparam logic [31:0] SAD_EMC_BASE   = 32'h10D0_0000;
    localparam logic [31:0] SAD_EMC_LAST   = 32'h10DF_FFFF;
    localparam logic [31:0] SAD_SDRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] SAD_SDRAM_LAST = 32'h2FFF_FFFF;
    localparam logic [31:0] SAD_ASYN_BASE  = 32'h3000_0000;
    localparam logic [31:0] SAD_ASYN_LAST  = 32'h3FFF_FFFF;
    localparam logic [31:0] SAD_PREG_BASE  = 32'h4000_0000;
    localparam logic [31:0] SAD_PREG_LAST  = 32'h4000_7FFF;
    localparam logic [31:0] SAD_ROM_BASE   = 32'h4000_8000;
    localparam logic [31:0] SAD_ROM_LAST   = 32'h4000_9FFF;
    localparam logic [31:0] SAD_SPI1_BASE  = 32'h4001_0000;
    localparam logic [31:0] SAD_SPI1_LAST  = 32'h4001_00FF;
    localparam logic [31:0] SAD_SPI2_BASE  = 32'h4001_1000;
    localparam logic [31:0] SAD_SPI2_LAST  = 32'h4001_10FF;
    localparam logic [31:0] SAD_WDOG_BASE  = 32'h4001_3000;
    localparam logic [31:0] SAD_WDOG_LAST  = 32'h4001_3FFF;
    localparam logic [31:0] SAD_FCNT_BASE  = 32'h4001_4000;
    localparam logic [31:0] SAD_FCNT_LAST  = 32'h4001_4FFF;
    localparam logic [31:0] SAD_IFLT_BASE  = 32'h4001_9000;
    localparam logic [31:0] SAD_IFLT_LAST  = 32'h4001_9FFF;

    // ----------------------------------------------------------------
    // physical sizes as address widths (log2 bytes)
    // ----------------------------------------------------------------
    localparam logic [5:0] SAD_AW_ROM   = 6'h0D;
    localparam logic [5:0] SAD_AW_LOW   = 6'h1A;
    localparam logic [5:0] SAD_AW_TCM   = 6'h12;
    localparam logic [5:0] SAD_AW_ICU   = 6'h17;
    localparam logic [5:0] SAD_AW_NET   = 6'h15;
    localparam logic [5:0] SAD_AW_PBUF  = 6'h10;
    localparam logic [5:0] SAD_AW_DMA   = 6'h14;
    localparam logic [5:0] SAD_AW_EMC   = 6'h14;
    localparam logic [5:0] SAD_AW_SDRAM = 6'h1C;
    localparam logic [5:0] SAD_AW_PREG  = 6'h0F;
    localparam logic [5:0] SAD_AW_SPI   = 6'h08;
    localparam logic [5:0] SAD_AW_WDOG  = 6'h05;
    localparam logic [5:0] SAD_AW_IFLT  = 6'h07;
    localparam logic [5:0] SAD_AW_FCNT  = 6'h03;
    localparam logic [5:0] SAD_AW_NONE  = 6'h00;
    localparam int          SAD_BANK_LSB = 26;

endpackage : sad_pkg

// File: sad_alias_mask.sv
/*
 * keeps only the low address bits that cover a target's physical size
 * assumes width below 32; higher bits come out as zero
 */
module sad_alias_mask (
    input  wire logic [31:0] addr,
    input  wire logic [5:0]  width,
    output logic      [31:0] offset
);
    // ----------------------------------------------------------------
    // mask
    // ----------------------------------------------------------------
    wire logic [31:0] keep_mask;

    assign keep_mask = (32'h0000_0001 << width) - 32'h0000_0001;
    assign offset    = addr & keep_mask;
endmodule // sad_alias_mask

// File: sad_decoder.sv
/*
 * system address decoder: picks one target per master access,
 * applies the low-window swap, tight memories and aliasing
 * assumes requests synchronous to mclk; the answer comes one
 * enabled edge later and targets take it from there
 */
// What this block does
// - swap 00b maps low window to repeated ROM
// - swap 01b maps low window to SDRAM
// - swap 10b maps low window to async memory
// - swap 11b gives timeout error in low window
// - enabled instruction tight memory serves low 256 KB to the instruction master
// - data tight memory sits up to 0803_FFFF
// - 1060_0000 to 107F_FFFF reaches network core
// - 2 MB window repeats 64 KB consistency buffer
// - DMA window splits registers, job SRAM, unused
// - memory controller registers, 1 MB, not aliased
// - segment 2 is SDRAM, single image
// - segment 3 is four mirrored async banks
// - segment 4 start holds 32 KB consistency registers
// - first SPI gets 256 B at 4001_0000
// - watchdog 4 KB slot repeats 32 bytes
// - input filter 4 KB slot repeats 128 bytes
// - frequency counter 4 KB slot repeats 8 bytes
// - bits without function read as zero
// - settings may change at any time
module sad_decoder
    import sad_pkg::*;
#(
    parameter logic [5:0] ASYNC_BANK_AW = 6'h1A
) (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire logic                 req_valid,
    input  wire logic [31:0]          req_addr,
    input  wire sad_pkg::sad_master_t req_master,
    input  wire sad_pkg::sad_swap_t   mem_swap,
    input  wire logic                 itcm_en,
    output logic                      req_ready,
    output logic                      resp_valid,
    output sad_pkg::sad_target_t      resp_target,
    output sad_pkg::sad_master_t      resp_master,
    output logic [31:0]               resp_offset,
    output logic [1:0]                resp_bank,
    output logic                      resp_err,
    output logic                      resp_timeout
);
    import sad_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [5:0] width_of(input sad_target_t t,
                                            input logic        low);
        case (t)
            SAD_T_BOOT_ROM: width_of = SAD_AW_ROM;
            SAD_T_SDRAM:    width_of = low ? SAD_AW_LOW : SAD_AW_SDRAM;
            SAD_T_ASYNC:    width_of = low ? SAD_AW_LOW : ASYNC_BANK_AW;
            SAD_T_ITCM:     width_of = SAD_AW_TCM;
            SAD_T_DTCM:     width_of = SAD_AW_TCM;
            SAD_T_ICU:      width_of = SAD_AW_ICU;
            SAD_T_NET:      width_of = SAD_AW_NET;
            SAD_T_PBUF:     width_of = SAD_AW_PBUF;
            SAD_T_DMA_REG:  width_of = SAD_AW_DMA;
            SAD_T_DMA_SRAM: width_of = SAD_AW_DMA;
            SAD_T_EMC_REG:  width_of = SAD_AW_EMC;
            SAD_T_PREG:     width_of = SAD_AW_PREG;
            SAD_T_SPI1:     width_of = SAD_AW_SPI;
            SAD_T_SPI2:     width_of = SAD_AW_SPI;
            SAD_T_WDOG:     width_of = SAD_AW_WDOG;
            SAD_T_IFILT:    width_of = SAD_AW_IFLT;
            SAD_T_FCNT:     width_of = SAD_AW_FCNT;
            default:        width_of = SAD_AW_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // window hits
    // ----------------------------------------------------------------
    wire logic hit_low   = in_range(req_addr, SAD_LOW_BASE, SAD_LOW_LAST);
    wire logic hit_itcm  = itcm_en && (req_master == SAD_M_INSTR)
                           && in_range(req_addr, SAD_LOW_BASE,
                                       SAD_ITCM_LAST);
    wire logic hit_dtcm  = in_range(req_addr, SAD_DTCM_BASE,
                                    SAD_DTCM_LAST);
    wire logic hit_icu   = in_range(req_addr, SAD_ICU_BASE, SAD_ICU_LAST);
    wire logic hit_net   = in_range(req_addr, SAD_NET_BASE,
                                    SAD_NET_LAST);
    wire logic hit_pbuf  = in_range(req_addr, SAD_PBUF_BASE,
                                    SAD_PBUF_LAST);
    wire logic hit_dmar  = in_range(req_addr, SAD_DMA_BASE,
                                    SAD_DMAR_LAST);
    wire logic hit_dmas  = in_range(req_addr, SAD_DMA_BASE,
                                    SAD_DMAS_LAST);
    wire logic hit_emc   = in_range(req_addr, SAD_EMC_BASE,
                                    SAD_EMC_LAST);
    wire logic hit_sdram = in_range(req_addr, SAD_SDRAM_BASE,
                                    SAD_SDRAM_LAST);
    wire logic hit_asyn  = in_range(req_addr, SAD_ASYN_BASE,
                                    SAD_ASYN_LAST);
    wire logic hit_preg  = in_range(req_addr, SAD_PREG_BASE,
                                    SAD_PREG_LAST);
    wire logic hit_rom   = in_range(req_addr, SAD_ROM_BASE,
                                    SAD_ROM_LAST);
    wire logic hit_spi1  = in_range(req_addr, SAD_SPI1_BASE,
                                    SAD_SPI1_LAST);
    wire logic hit_spi2  = in_range(req_addr, SAD_SPI2_BASE,
                                    SAD_SPI2_LAST);
    wire logic hit_wdog  = in_range(req_addr, SAD_WDOG_BASE,
                                    SAD_WDOG_LAST);
    wire logic hit_ifilt = in_range(req_addr, SAD_IFLT_BASE,
                                    SAD_IFLT_LAST);
    wire logic hit_fcnt  = in_range(req_addr, SAD_FCNT_BASE,
                                    SAD_FCNT_LAST);

    // ----------------------------------------------------------------
    // target selection
    // ----------------------------------------------------------------
    wire logic        low_swap = hit_low && !hit_itcm;
    wire sad_target_t low_target =
        (mem_swap == SAD_SWAP_ROM)   ? SAD_T_BOOT_ROM :
        (mem_swap == SAD_SWAP_SDRAM) ? SAD_T_SDRAM :
        (mem_swap == SAD_SWAP_ASYNC) ? SAD_T_ASYNC :
                                       SAD_T_NONE;
    wire sad_target_t next_target =
        hit_itcm  ? SAD_T_ITCM :
        low_swap  ? low_target :
        hit_dtcm  ? SAD_T_DTCM :
        hit_icu   ? SAD_T_ICU :
        hit_net   ? SAD_T_NET :
        hit_pbuf  ? SAD_T_PBUF :
        hit_dmar  ? SAD_T_DMA_REG :
        hit_dmas  ? SAD_T_DMA_SRAM :
        hit_emc   ? SAD_T_EMC_REG :
        hit_sdram ? SAD_T_SDRAM :
        hit_asyn  ? SAD_T_ASYNC :
        hit_preg  ? SAD_T_PREG :
        hit_rom   ? SAD_T_BOOT_ROM :
        hit_spi1  ? SAD_T_SPI1 :
        hit_spi2  ? SAD_T_SPI2 :
        hit_wdog  ? SAD_T_WDOG :
        hit_ifilt ? SAD_T_IFILT :
        hit_fcnt  ? SAD_T_FCNT :
                    SAD_T_NONE;
    wire logic        next_timeout = low_swap
                                     && (mem_swap == SAD_SWAP_TIMEOUT);
    wire logic        next_err     = (next_target == SAD_T_NONE);
    wire logic [5:0]  next_width   = width_of(next_target, low_swap);
    wire logic [1:0]  next_bank    = low_swap ? 2'h0
                                   : req_addr[SAD_BANK_LSB +: 2];
    logic      [31:0] next_offset;

    sad_alias_mask u_mask (
        .addr   (req_addr),
        .width  (next_width),
        .offset (next_offset)
    );

    // ----------------------------------------------------------------
    // answer registers
    // ----------------------------------------------------------------
    assign req_ready = clk_en;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            resp_valid <= 1'b0;
        end else if (clk_en) begin
            resp_valid <= req_valid;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            resp_target  <= SAD_T_NONE;
            resp_master  <= SAD_M_INSTR;
            resp_offset  <= 32'h0000_0000;
            resp_bank    <= 2'h0;
            resp_err     <= 1'b0;
            resp_timeout <= 1'b0;
        end else if (clk_en && req_valid) begin
            resp_target  <= next_target;
            resp_master  <= req_master;
            resp_offset  <= next_err ? 32'h0000_0000 : next_offset;
            resp_bank    <= (next_target == SAD_T_ASYNC) ? next_bank
                                                         : 2'h0;
            resp_err     <= next_err;
            resp_timeout <= next_timeout;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    wire logic req_go = clk_en && req_valid;
    wire logic low_req = req_go && hit_low && !hit_itcm;

    property p_rom_swap;
        @(posedge mclk) disable iff (!reset_n)
        low_req && mem_swap == SAD_SWAP_ROM |=> resp_target == SAD_T_BOOT_ROM
            && resp_offset == {19'h0, $past(req_addr[12:0])};
    endproperty
    a_rom_swap: assert property (p_rom_swap)
        else $error("low window not on repeated boot rom");

    property p_sdram_swap;
        @(posedge mclk) disable iff (!reset_n)
        low_req && mem_swap == SAD_SWAP_SDRAM |=> resp_target == SAD_T_SDRAM
            && resp_offset == {6'h0, $past(req_addr[25:0])};
    endproperty
    a_sdram_swap: assert property (p_sdram_swap)
        else $error("low window not on sdram");

    property p_async_swap;
        @(posedge mclk) disable iff (!reset_n)
        low_req && mem_swap == SAD_SWAP_ASYNC |=> resp_target == SAD_T_ASYNC
            && resp_offset == $past(req_addr) && resp_bank == 2'h0;
    endproperty
    a_async_swap: assert property (p_async_swap)
        else $error("low window not on async memory");

    property p_timeout;
        @(posedge mclk) disable iff (!reset_n)
        low_req && mem_swap == SAD_SWAP_TIMEOUT
            |=> resp_timeout && resp_err && resp_target == SAD_T_NONE;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout mode did not give an error");

    property p_itcm;
        @(posedge mclk) disable iff (!reset_n)
        req_go && itcm_en && req_master == SAD_M_INSTR
            && req_addr <= SAD_ITCM_LAST
            |=> resp_target == SAD_T_ITCM && !resp_timeout;
    endproperty
    a_itcm: assert property (p_itcm)
        else $error("instruction tight memory not selected");

    property p_net;
        @(posedge mclk) disable iff (!reset_n)
        req_go && hit_net |=> resp_target == SAD_T_NET
            && resp_offset == $past(req_addr) - SAD_NET_BASE;
    endproperty
    a_net: assert property (p_net)
        else $error("network core window wrong");

    property p_pbuf;
        @(posedge mclk) disable iff (!reset_n)
        req_go && hit_pbuf |=> resp_target == SAD_T_PBUF
            && resp_offset[31:16] == 16'h0000;
    endproperty
    a_pbuf: assert property (p_pbuf)
        else $error("consistency buffer not repeated");

    property p_dma_split;
        @(posedge mclk) disable iff (!reset_n)
        req_go && in_range(req_addr, SAD_DMA_BASE, SAD_DMA_LAST)
            |=> (resp_target == SAD_T_DMA_REG)
                == ($past(req_addr) <= SAD_DMAR_LAST)
            && resp_err == ($past(req_addr) > SAD_DMAS_LAST);
    endproperty
    a_dma_split: assert property (p_dma_split)
        else $error("dma window split wrong");

    property p_wdog;
        @(posedge mclk) disable iff (!reset_n)
        req_go && hit_wdog |=> resp_target == SAD_T_WDOG
            && resp_offset == {27'h0, $past(req_addr[4:0])};
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog slot not repeated");

    property p_unmapped;
        @(posedge mclk) disable iff (!reset_n)
        req_go && next_target == SAD_T_NONE
            |=> resp_err && resp_offset == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_hold;
        @(posedge mclk) disable iff (!reset_n)
        !clk_en |=> $stable(resp_valid) && $stable(resp_target);
    endproperty
    a_hold: assert property (p_hold)
        else $error("answer moved while clock enable low");

    c_boot: cover property (@(posedge mclk) disable iff (!reset_n)
        low_req && mem_swap == SAD_SWAP_ROM);
    c_bank3: cover property (@(posedge mclk) disable iff (!reset_n)
        req_go && hit_asyn && req_addr[SAD_BANK_LSB +: 2] == 2'h3);
    c_err: cover property (@(posedge mclk) disable iff (!reset_n)
        resp_valid && resp_err);
    c_b2b: cover property (@(posedge mclk) disable iff (!reset_n)
        resp_valid [*3]);
endmodule // sad_decoder

// File: sad_master_model.sv
/*
 * bus master model: issues one access at a time to the decoder
 * and captures its answer
 * assumes the decoder's mclk and sad_pkg compiled first
 */
module sad_master_model (
    input  wire logic                 mclk,
    output logic                      req_valid,
    output logic [31:0]               req_addr,
    output sad_pkg::sad_master_t      req_master,
    input  wire logic                 req_ready,
    input  wire logic                 resp_valid,
    input  wire sad_pkg::sad_target_t resp_target,
    input  wire sad_pkg::sad_master_t resp_master,
    input  wire logic [31:0]          resp_offset,
    input  wire logic [1:0]           resp_bank,
    input  wire logic                 resp_err,
    input  wire logic                 resp_timeout
);
    timeunit 1ns;
    timeprecision 1ps;
    import sad_pkg::*;
    logic        got_valid;
    sad_target_t got_target;
    sad_master_t got_master;
    logic [31:0] got_offset;
    logic [1:0]  got_bank;
    logic        got_err;
    logic        got_tmo;

    initial begin
        req_valid  = 1'b0;
        req_addr   = 32'h0;
        req_master = SAD_M_INSTR;
    end

    // ----------------------------------------------------------------
    // one access: hold until taken, read the answer half a cycle later
    // ----------------------------------------------------------------
    task automatic access(input sad_master_t m, input logic [31:0] a);
        @(negedge mclk);
        req_valid  = 1'b1;
        req_addr   = a;
        req_master = m;
        @(posedge mclk);
        while (req_ready !== 1'b1) @(posedge mclk);
        @(negedge mclk);
        got_valid  = resp_valid;
        got_target = resp_target;
        got_master = resp_master;
        got_offset = resp_offset;
        got_bank   = resp_bank;
        got_err    = resp_err;
        got_tmo    = resp_timeout;
        req_valid  = 1'b0;
        req_addr   = ~a;
    endtask
endmodule // sad_master_model

// File: system_address_decoder_tb_top.sv
/*
 * bench of the system address decoder: accesses through the
 * master model, each answer checked against the address map
 * assumes sad_pkg, the decoder and the master model compiled first
 */
module system_address_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sad_pkg::*;
    logic        mclk, reset_n, clk_en, itcm_en, req_valid, req_ready;
    logic        resp_valid, resp_err, resp_timeout;
    logic [31:0] req_addr, resp_offset;
    logic [1:0]  resp_bank;
    sad_master_t req_master, resp_master;
    sad_swap_t   mem_swap;
    sad_target_t resp_target;
    int          fails, samples_checked, cycles;

    sad_decoder #(.ASYNC_BANK_AW(6'h14)) dut (.mclk(mclk),
        .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
        .req_addr(req_addr), .req_master(req_master),
        .mem_swap(mem_swap), .itcm_en(itcm_en), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_target(resp_target),
        .resp_master(resp_master), .resp_offset(resp_offset),
        .resp_bank(resp_bank), .resp_err(resp_err),
        .resp_timeout(resp_timeout));
    sad_master_model u_master (.mclk(mclk), .req_valid(req_valid),
        .req_addr(req_addr), .req_master(req_master),
        .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_target(resp_target), .resp_master(resp_master),
        .resp_offset(resp_offset), .resp_bank(resp_bank),
        .resp_err(resp_err), .resp_timeout(resp_timeout));

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic hit(input sad_master_t m, input logic [31:0] a,
                       input sad_target_t t, input logic [31:0] o,
                       input logic [1:0] b, input logic e, input logic x);
        u_master.access(m, a);
        chk("valid", 32'h1, {31'h0, u_master.got_valid});
        chk("target", {27'h0, t}, {27'h0, u_master.got_target});
        chk("master", {30'h0, m}, {30'h0, u_master.got_master});
        chk("offset", o, u_master.got_offset);
        chk("bank", {30'h0, b}, {30'h0, u_master.got_bank});
        chk("err", {31'h0, e}, {31'h0, u_master.got_err});
        chk("timeout", {31'h0, x}, {31'h0, u_master.got_tmo});
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_swap;
        mem_swap = SAD_SWAP_ROM;
        hit(SAD_M_DATA, 32'h0100_2345, SAD_T_BOOT_ROM,
            32'h345, 2'h0, 1'b0, 1'b0);
        mem_swap = SAD_SWAP_SDRAM;
        hit(SAD_M_DMA, 32'h0100_2345, SAD_T_SDRAM,
            32'h0100_2345, 2'h0, 1'b0, 1'b0);
        mem_swap = SAD_SWAP_ASYNC;
        hit(SAD_M_HOST, 32'h03FF_FFF0, SAD_T_ASYNC,
            32'h03FF_FFF0, 2'h0, 1'b0, 1'b0);
        mem_swap = SAD_SWAP_TIMEOUT;
        hit(SAD_M_DATA, 32'h0000_0100, SAD_T_NONE,
            32'h0, 2'h0, 1'b1, 1'b1);
        mem_swap = SAD_SWAP_ROM;
        $display("test swap done");
    endtask
    task automatic test_tcm;
        itcm_en = 1'b1;
        hit(SAD_M_INSTR, 32'h0003_FFFC, SAD_T_ITCM,
            32'h3FFFC, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_INSTR, 32'h0004_0000, SAD_T_BOOT_ROM,
            32'h0, 2'h0, 1'b0, 1'b0);
        itcm_en = 1'b0;
        hit(SAD_M_INSTR, 32'h0000_0010, SAD_T_BOOT_ROM,
            32'h10, 2'h0, 1'b0, 1'b0);
        $display("test tcm done");
    endtask
    task automatic test_map;
        hit(SAD_M_DATA, 32'h0803_FFFF, SAD_T_DTCM,
            32'h3FFFF, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h1012_3456, SAD_T_ICU,
            32'h123456, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h107F_FFF0, SAD_T_NET,
            32'h1FFFF0, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DMA, 32'h109F_1234, SAD_T_PBUF,
            32'h1234, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h10A0_00AF, SAD_T_DMA_REG,
            32'hAF, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h10A0_12AF, SAD_T_DMA_SRAM,
            32'h12AF, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DMA, 32'h10A0_12B0, SAD_T_NONE,
            32'h0, 2'h0, 1'b1, 1'b0);
        hit(SAD_M_DATA, 32'h10D4_5678, SAD_T_EMC_REG,
            32'h45678, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DMA, 32'h2ABC_DEF0, SAD_T_SDRAM,
            32'hABCDEF0, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h3B12_3456, SAD_T_ASYNC,
            32'h23456, 2'h2, 1'b0, 1'b0);
        hit(SAD_M_DATA, 32'h3FF1_2345, SAD_T_ASYNC,
            32'h12345, 2'h3, 1'b0, 1'b0);
        hit(SAD_M_DATA, 32'h4000_7FFF, SAD_T_PREG,
            32'h7FFF, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DATA, 32'h4000_8ABC, SAD_T_BOOT_ROM,
            32'hABC, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h4001_00FF, SAD_T_SPI1,
            32'hFF, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h4001_1080, SAD_T_SPI2,
            32'h80, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DATA, 32'h4001_3FE4, SAD_T_WDOG,
            32'h4, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DATA, 32'h4001_9F85, SAD_T_IFILT,
            32'h5, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_DMA, 32'h4001_4FFB, SAD_T_FCNT,
            32'h3, 2'h0, 1'b0, 1'b0);
        hit(SAD_M_HOST, 32'h4001_0100, SAD_T_NONE,
            32'h0, 2'h0, 1'b1, 1'b0);
        hit(SAD_M_INSTR, 32'h5000_0000, SAD_T_NONE,
            32'h0, 2'h0, 1'b1, 1'b0);
        $display("test map done");
    endtask
    task automatic test_freeze;
        hit(SAD_M_HOST, 32'h4001_0004, SAD_T_SPI1,
            32'h4, 2'h0, 1'b0, 1'b0);
        clk_en = 1'b0;
        repeat (3) @(negedge mclk);
        chk("frozen valid", 32'h1, {31'h0, resp_valid});
        clk_en = 1'b1;
        @(negedge mclk);
        chk("idle valid", 32'h0, {31'h0, resp_valid});
        reset_n = 1'b0;
        @(negedge mclk);
        chk("reset target", 32'h0, {27'h0, resp_target});
        chk("reset master", 32'h0, {30'h0, resp_master});
        chk("reset offset", 32'h0, resp_offset);
        reset_n = 1'b1;
        $display("test freeze done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        fails           = 0;
        samples_checked = 0;
        reset_n  = 1'b0;
        clk_en   = 1'b1;
        itcm_en  = 1'b0;
        mem_swap = SAD_SWAP_ROM;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        chk("reset valid", 32'h0, {31'h0, resp_valid});
        test_swap();
        test_tcm();
        test_map();
        test_freeze();
        give_verdict();
    end
endmodule // system_address_decoder_tb_top
